// ---- rtl/lpcd_decoder.sv ----
`timescale 1ns/1ps
`default_nettype none

module lpcd_decoder
    import lpcd_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic [CA_W-1:0] ca_rise,
    input wire logic [CA_W-1:0] ca_fall,
    input wire logic all_banks_idle,
    input wire logic in_resetting,
    input wire logic init_final_expired,
    input wire logic init_restart,
    input wire logic eight_bank_cfg,
    input wire logic clk_resumed,
    output lpcd_cmd_t cmd,
    output lpcd_pstate_t power_state,
    output logic cmd_ready,
    output logic illegal_cmd,
    output logic pd_exit_to_idle
);

    // ==========================================================
    // Pin synchronisation
    logic [SYNC_W-1:0] sync_q;
    logic s_cke;
    logic s_cs_n;
    logic [CA_W-1:0] r;
    logic [CA_W-1:0] f;
    logic cke_prev;

    lpcd_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .clk(clk),
        .srst(srst),
        .async_in({cke, cs_n, ca_rise, ca_fall}),
        .sync_out(sync_q)
    );

    // Split synchronised word; rising and falling halves pair
    assign {s_cke, s_cs_n, r, f} = sync_q;

    // Previous-edge clock enable
    always_ff @(posedge clk)
    begin
        if (srst)
            cke_prev <= 1'b0;
        else
            cke_prev <= s_cke;
    end

    // ==========================================================
    // Exit and clock-resume delay timer
    logic timer_load;
    logic [TIMER_W-1:0] timer_count;
    logic timer_busy;

    lpcd_timer u_timer (
        .clk(clk),
        .srst(srst),
        .load(timer_load),
        .load_count(timer_count),
        .busy(timer_busy)
    );

    // ==========================================================
    // Command decode
    logic cke_steady_high;
    logic is_no_op;
    logic cmd_slot;
    lpcd_cmd_t next_cmd;
    logic decode_illegal;

    // Steady-high cke and no-op detect
    assign cke_steady_high = cke_prev & s_cke;
    assign is_no_op = s_cs_n | (r[2:0] == OPC3_NO_OP);
    assign cmd_slot = (power_state == ps_awake) && cke_steady_high
        && !is_no_op;

    // Field extraction and opcode match
    always_comb
    begin
        next_cmd = '0;
        next_cmd.kind = cmd_none;
        decode_illegal = 1'b0;
        if (cmd_slot && !cmd_ready)
            decode_illegal = 1'b1; // Command inside exit delay
        else if (cmd_slot)
        begin
            next_cmd.valid = 1'b1;
            next_cmd.bank = r[BANK_LSB +: BANK_W];
            casez (r[OPC_W-1:0])
                OPC_MODE_WRITE:
                begin
                    next_cmd.kind = cmd_mode_reg_write;
                    next_cmd.mode_reg_index = {f[MR_IDX_F_W-1:0],
                        r[MR_IDX_R_LSB +: MR_IDX_R_W]};
                    next_cmd.mode_reg_value = f[MR_VAL_F_LSB +: MR_W];
                end
                OPC_MODE_READ:
                begin
                    next_cmd.kind = cmd_mode_reg_read;
                    next_cmd.mode_reg_index = {f[MR_IDX_F_W-1:0],
                        r[MR_IDX_R_LSB +: MR_IDX_R_W]};
                end
                OPC_REF_ONE:
                begin
                    // Only eight-bank parts take it
                    next_cmd.kind = cmd_refresh_one_bank;
                    next_cmd.valid = eight_bank_cfg;
                    decode_illegal = !eight_bank_cfg;
                end
                OPC_REF_ALL:
                    next_cmd.kind = cmd_refresh_all_banks;
                OPC_ACTIVATE:
                begin
                    next_cmd.kind = cmd_activate;
                    next_cmd.row = {f[ROW_F_HI_LSB +: ROW_F_HI_W],
                        r[ROW_R_LSB +: ROW_R_W],
                        f[ROW_F_LO_W-1:0]};
                end
                OPC_WRITE, OPC_READ:
                begin
                    // Reserved bits 3-4 are not looked at
                    next_cmd.kind = r[2] ? cmd_read : cmd_write;
                    next_cmd.column = {f[COL_F_LSB +: COL_F_W],
                        r[COL_R_LSB +: COL_R_W],
                        COL_BIT0_VALUE};
                    next_cmd.auto_close_flag = f[AUTO_CLOSE_POS];
                end
                OPC_PRECHARGE:
                begin
                    next_cmd.kind = cmd_precharge;
                    next_cmd.all_bank_flag = r[ALL_BANK_POS];
                    if (r[ALL_BANK_POS])
                        next_cmd.bank = '0; // Bank ignored
                end
                OPC_BURST_STOP:
                    next_cmd.kind = cmd_burst_stop;
                default:
                begin
                    next_cmd.valid = 1'b0;
                    decode_illegal = 1'b1;
                end
            endcase
        end
    end

    // Registered command; no-op yields no strobe, bursts go on
    always_ff @(posedge clk)
    begin
        if (srst)
            cmd <= '0;
        else
            cmd <= next_cmd;
    end

    // ==========================================================
    // Power state machine
    lpcd_pstate_t next_state;
    logic entry_illegal;
    logic exit_idle;

    // Clock-enable pair decides entry, exit or hold
    always_comb
    begin
        next_state = power_state;
        entry_illegal = 1'b0;
        exit_idle = 1'b0;
        timer_load = 1'b0;
        timer_count = CLK_RESUME_CYC;
        case (power_state)
            ps_power_on:
                if (init_restart)
                    next_state = ps_awake;
            ps_awake:
                if (cke_prev && !s_cke)
                begin
                    if (s_cs_n)
                    begin
                        // Power-down flavour from bank state
                        if (in_resetting)
                            next_state = ps_pd_resetting;
                        else if (all_banks_idle)
                            next_state = ps_pd_idle;
                        else
                            next_state = ps_pd_active;
                    end
                    else if (all_banks_idle
                        && r[2:0] == OPC3_SELF_REFRESH)
                        next_state = ps_self_refresh_mode;
                    else if (all_banks_idle
                        && r[2:0] == OPC3_DEEP_SLEEP)
                        next_state = ps_deep_sleep_mode;
                    else
                        entry_illegal = 1'b1;
                end
                else if (clk_resumed)
                    timer_load = 1'b1; // Two clocks plus exit delay
            ps_pd_active, ps_pd_idle, ps_pd_resetting:
                if (!cke_prev && s_cke)
                begin
                    if (s_cs_n)
                    begin
                        // Exit with cs high
                        next_state = ps_awake;
                        timer_load = 1'b1;
                        exit_idle = (power_state != ps_pd_resetting)
                            || init_final_expired;
                    end
                    else
                        entry_illegal = 1'b1;
                end
            ps_self_refresh_mode:
                if (s_cke && s_cs_n)
                begin
                    // Asynchronous exit, bus contents ignored
                    next_state = ps_awake;
                    timer_load = 1'b1;
                    timer_count = SR_EXIT_CYC;
                    exit_idle = 1'b1; // Self refresh exits to idle
                end
            ps_deep_sleep_mode:
                if (s_cke && s_cs_n)
                    next_state = ps_power_on;
            default:
                next_state = ps_power_on;
        endcase
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (srst)
            power_state <= ps_power_on;
        else
            power_state <= next_state;
    end

    // Ready once awake and no exit delay runs
    always_ff @(posedge clk)
    begin
        if (srst)
            cmd_ready <= 1'b0;
        else
            cmd_ready <= (next_state == ps_awake) && !timer_load
                && !timer_busy;
    end

    // Illegal event pulse
    always_ff @(posedge clk)
    begin
        if (srst)
            illegal_cmd <= 1'b0;
        else
            illegal_cmd <= decode_illegal | entry_illegal;
    end

    // Power-down exit target: idle or still resetting
    always_ff @(posedge clk)
    begin
        if (srst)
            pd_exit_to_idle <= 1'b0;
        else if (timer_load && power_state != ps_awake)
            pd_exit_to_idle <= exit_idle;
    end

endmodule

`default_nettype wire

// ---- pkg/lpcd_pkg.sv ----
package lpcd_pkg;

    // ==========================================================
    // Bus widths and command-bus field positions
    localparam int CA_W = 10;
    localparam int SYNC_W = 2 * CA_W + 2;
    localparam int BANK_LSB = 7;
    localparam int BANK_W = 3;
    localparam int ROW_W = 15;
    localparam int COL_W = 12;
    localparam int MR_W = 8;
    localparam int OPC_W = 4;
    // Mode register index, rising half and falling half
    localparam int MR_IDX_R_LSB = 4;
    localparam int MR_IDX_R_W = 6;
    localparam int MR_IDX_F_W = 2;
    localparam int MR_VAL_F_LSB = 2;
    // Activate row pieces
    localparam int ROW_R_LSB = 2;
    localparam int ROW_R_W = 5;
    localparam int ROW_F_LO_W = 8;
    localparam int ROW_F_HI_LSB = 8;
    localparam int ROW_F_HI_W = 2;
    // Column pieces and flags
    localparam int COL_R_LSB = 5;
    localparam int COL_R_W = 2;
    localparam int COL_F_LSB = 1;
    localparam int COL_F_W = 9;
    localparam int AUTO_CLOSE_POS = 0;
    localparam int ALL_BANK_POS = 4;
    localparam logic COL_BIT0_VALUE = 1'b0;

    // ==========================================================
    // Rising-edge opcodes on command bits 3..0 (bit 0 rightmost)
    localparam logic [OPC_W-1:0] OPC_MODE_WRITE = 4'b0000;
    localparam logic [OPC_W-1:0] OPC_MODE_READ = 4'b1000;
    localparam logic [OPC_W-1:0] OPC_REF_ONE = 4'b0100;
    localparam logic [OPC_W-1:0] OPC_REF_ALL = 4'b1100;
    localparam logic [OPC_W-1:0] OPC_ACTIVATE = 4'b??10;
    localparam logic [OPC_W-1:0] OPC_WRITE = 4'b?001;
    localparam logic [OPC_W-1:0] OPC_READ = 4'b?101;
    localparam logic [OPC_W-1:0] OPC_PRECHARGE = 4'b1011;
    localparam logic [OPC_W-1:0] OPC_BURST_STOP = 4'b0011;
    localparam logic [2:0] OPC3_NO_OP = 3'h7;
    localparam logic [2:0] OPC3_SELF_REFRESH = 3'h4;
    localparam logic [2:0] OPC3_DEEP_SLEEP = 3'h3;

    // ==========================================================
    // Timing, clock 200 MHz
    localparam int CLK_PERIOD_PS = 5000;
    localparam int PD_EXIT_DELAY_NS = 10;
    localparam int SR_EXIT_DELAY_NS = 140;
    localparam int CLK_STABLE_CYC = 2;
    localparam int TIMER_W = 8;
    localparam logic [TIMER_W-1:0] PD_EXIT_CYC =
        TIMER_W'((PD_EXIT_DELAY_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS);
    localparam logic [TIMER_W-1:0] SR_EXIT_CYC =
        TIMER_W'((SR_EXIT_DELAY_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS);
    localparam logic [TIMER_W-1:0] CLK_RESUME_CYC =
        TIMER_W'(CLK_STABLE_CYC) + PD_EXIT_CYC;

    // ==========================================================
    // Types
    typedef enum logic [3:0] {
        cmd_none,
        cmd_mode_reg_write,
        cmd_mode_reg_read,
        cmd_refresh_one_bank,
        cmd_refresh_all_banks,
        cmd_activate,
        cmd_write,
        cmd_read,
        cmd_precharge,
        cmd_burst_stop
    } lpcd_kind_t;

    typedef enum logic [3:0] {
        ps_power_on,
        ps_awake,
        ps_pd_active,
        ps_pd_idle,
        ps_pd_resetting,
        ps_self_refresh_mode,
        ps_deep_sleep_mode
    } lpcd_pstate_t;

    typedef struct packed {
        logic valid;
        lpcd_kind_t kind;
        logic [BANK_W-1:0] bank;
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] column;
        logic [MR_W-1:0] mode_reg_index;
        logic [MR_W-1:0] mode_reg_value;
        logic auto_close_flag;
        logic all_bank_flag;
    } lpcd_cmd_t;

endpackage

// ---- rtl/lpcd_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module lpcd_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // ==========================================================
    // Two-stage synchroniser, one per bit
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            logic stage1;
            always_ff @(posedge clk)
            begin
                if (srst)
                begin
                    stage1 <= 1'b0;
                    sync_out[i] <= 1'b0;
                end
                else
                begin
                    stage1 <= async_in[i];
                    sync_out[i] <= stage1;
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// ---- rtl/lpcd_timer.sv ----
`timescale 1ns/1ps
`default_nettype none

module lpcd_timer
    import lpcd_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic load,
    input wire logic [TIMER_W-1:0] load_count,
    output logic busy
);

    logic [TIMER_W-1:0] remaining;

    // ==========================================================
    // Down counter; a new load restarts it
    always_ff @(posedge clk)
    begin
        if (srst)
            remaining <= '0;
        else if (load)
            remaining <= load_count;
        else if (remaining != '0)
            remaining <= remaining - TIMER_W'(1);
    end

    // Busy while cycles remain
    always_ff @(posedge clk)
    begin
        if (srst)
            busy <= 1'b0;
        else
            busy <= load ? (load_count != '0) : (remaining > TIMER_W'(1));
    end

endmodule

`default_nettype wire

// ---- tb/lpcd_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module lpcd_ctrl_model
    import lpcd_pkg::*;
(
    input wire logic clk,
    input wire logic req_cs_n,
    input wire logic req_cke,
    input wire logic [CA_W-1:0] req_rise,
    input wire logic [CA_W-1:0] req_fall,
    output var logic cke = 1'b1,
    output var logic cs_n = 1'b1,
    output var logic [CA_W-1:0] ca_rise = 10'h000,
    output var logic [CA_W-1:0] ca_fall = 10'h000
);
    // ==========
    // Pin driver
    // Pins move just after the edge, one request a cycle
    always @(posedge clk)
    begin
        cke <= req_cke;
        cs_n <= req_cs_n;
        // Deselected bus flips every cycle
        ca_rise <= req_cs_n ? ~ca_rise : req_rise;
        ca_fall <= req_cs_n ? ~ca_fall : req_fall;
    end
endmodule
`default_nettype wire

// ---- tb/lpcd_decoder_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module lpcd_decoder_asserts
    import lpcd_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic [CA_W-1:0] ca_rise,
    input wire logic [CA_W-1:0] ca_fall,
    input wire logic all_banks_idle,
    input wire logic clk_resumed,
    input wire lpcd_cmd_t cmd,
    input wire lpcd_pstate_t power_state,
    input wire logic cmd_ready
);
    // ==========
    // Decode, power-state and ready checks
    wire logic rw = cmd.kind inside {cmd_read, cmd_write};
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    a_cmd_needs_sel: assert property (cmd.valid |->
        $past(!cs_n, 3) && $past(cke, 3) && $past(cke, 4))
        else $error("command without select");
    a_nop_no_cmd: assert property ((cs_n ||
        ca_rise[2:0] == OPC3_NO_OP) && cke && $past(cke) |-> ##3 !cmd.valid)
        else $error("no-op decoded");
    a_bank_field: assert property (cmd.valid && (rw ||
        cmd.kind == cmd_activate) |-> cmd.bank == $past(ca_rise[9:7], 3))
        else $error("bank field wrong");
    a_column_map: assert property (cmd.valid && rw |->
        cmd.column == {$past(ca_fall[9:1], 3), $past(ca_rise[6:5], 3), 1'b0}
        && cmd.auto_close_flag == $past(ca_fall[0], 3))
        else $error("column or auto close wrong");
    a_all_bank: assert property (cmd.valid && cmd.all_bank_flag &&
        cmd.kind == cmd_precharge |-> cmd.bank == 3'h0 && $past(ca_rise[4], 3))
        else $error("all bank flag wrong");
    a_mode_index: assert property (cmd.valid && cmd.kind inside
        {cmd_mode_reg_write, cmd_mode_reg_read} |-> cmd.mode_reg_index ==
        {$past(ca_fall[1:0], 3), $past(ca_rise[9:4], 3)})
        else $error("mode index wrong");
    a_sr_entry: assert property ($fell(cke) && !cs_n && cmd_ready &&
        ca_rise[2:0] == OPC3_SELF_REFRESH && all_banks_idle &&
        power_state == ps_awake |-> ##3 power_state == ps_self_refresh_mode)
        else $error("self refresh not entered");
    a_pd_exit: assert property ($rose(cke) && cs_n && power_state
        inside {ps_pd_active, ps_pd_idle, ps_self_refresh_mode}
        |-> ##3 power_state == ps_awake)
        else $error("power-down exit missed");
    a_deep_exit: assert property ($rose(cke) && cs_n &&
        power_state == ps_deep_sleep_mode |-> ##3 power_state == ps_power_on)
        else $error("deep sleep exit missed");
    a_ready_delay: assert property (clk_resumed &&
        power_state == ps_awake |-> ##2 !cmd_ready [*2] ##[1:8] cmd_ready)
        else $error("ready delay wrong");
endmodule
bind lpcd_decoder lpcd_decoder_asserts lpcd_decoder_asserts_i (.clk, .srst,
    .cke, .cs_n, .ca_rise, .ca_fall, .all_banks_idle, .clk_resumed, .cmd,
    .power_state, .cmd_ready);
`default_nettype wire

// ---- tb/lpddr2_command_cke_decoder_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
    $display("Error %s exp %0h got %0h", n, e, g); end end
module lpddr2_command_cke_decoder_tb;
    import lpcd_pkg::*;
    typedef struct packed {
        logic cs;
        logic [9:0] r;
        logic [9:0] f;
        lpcd_kind_t k;
    } lpcd_row_t;
    // ==========
    // Stimulus state
    logic clk = 0, srst = 1, rq_cke = 1, rq_cs = 1, all_banks_idle = 1;
    logic in_resetting = 0, init_final_expired = 0, init_restart = 0;
    logic eight_bank_cfg = 1, clk_resumed = 0, cmd_ready, illegal_cmd, ill;
    logic pd_exit_to_idle, cke, cs_n;
    logic [9:0] rq_r = 0, rq_f = 0, ca_rise, ca_fall;
    lpcd_cmd_t cmd, got;
    lpcd_pstate_t power_state;
    int fail_count = 0, checked = 0, n;
    lpcd_row_t rows [12] = '{'{0, 10'h250, 10'h0f2, cmd_mode_reg_write},
        '{0, 10'h3f8, 10'h003, cmd_mode_reg_read},
        '{0, 10'h004, 10'h000, cmd_refresh_one_bank},
        '{0, 10'h00c, 10'h3ff, cmd_refresh_all_banks},
        '{0, 10'h2b6, 10'h2a5, cmd_activate},
        '{0, 10'h1f9, 10'h155, cmd_write},
        '{0, 10'h345, 10'h2aa, cmd_read},
        '{0, 10'h38b, 10'h3ff, cmd_precharge},
        '{0, 10'h11b, 10'h000, cmd_precharge},
        '{0, 10'h3c3, 10'h000, cmd_burst_stop},
        '{0, 10'h3ff, 10'h000, cmd_none},
        '{1, 10'h000, 10'h000, cmd_none}};
    lpcd_ctrl_model lpcd_ctrl_model_i (.clk, .req_cs_n(rq_cs),
        .req_cke(rq_cke), .req_rise(rq_r), .req_fall(rq_f), .cke, .cs_n,
        .ca_rise, .ca_fall);
    lpcd_decoder lpcd_decoder_i (.clk, .srst, .cke, .cs_n, .ca_rise,
        .ca_fall, .all_banks_idle, .in_resetting, .init_final_expired,
        .init_restart, .eight_bank_cfg, .clk_resumed, .cmd, .power_state,
        .cmd_ready, .illegal_cmd, .pd_exit_to_idle);
    // Clock, 5 ns period
    initial
    begin
        forever #2.5 clk = ~clk;
    end
    // ==========
    // Tasks
    task automatic end_sim;
        $display("Checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic send(input logic c, k, input logic [9:0] r, f);
        @(posedge clk);
        rq_cs <= c;
        rq_cke <= k;
        rq_r <= r;
        rq_f <= f;
    endtask
    task automatic hold(input logic k, input int c);
        repeat (c) send(1, k, 0, 0);
    endtask
    task automatic collect;
        got = '0;
        ill = 0;
        n = 0;
        repeat (10)
        begin
            @(posedge clk);
            #1;
            if (cmd.valid === 1'b1)
            begin
                got = cmd;
                n++;
            end
            if (illegal_cmd === 1'b1)
                ill = 1;
        end
    endtask
    task automatic wait_st(input lpcd_pstate_t s);
        #1;
        repeat (20)
            if (power_state !== s)
            begin
                @(posedge clk);
                #1;
            end
        `CHK("state", s, power_state)
        if (power_state !== s)
            end_sim;
    endtask
    task automatic wait_rdy;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 40)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK("ready", 1'b1, cmd_ready)
        if (cmd_ready !== 1'b1)
            end_sim;
    endtask
    task automatic start;
        @(posedge clk);
        init_restart <= 1'b1;
        @(posedge clk);
        init_restart <= 1'b0;
        wait_st(ps_awake);
        wait_rdy;
    endtask
    // Hang guard
    initial
    begin
        #200000;
        fail_count++;
        end_sim;
    end
    // ==========
    // Main sequence
    initial
    begin
        repeat (12) @(posedge clk);
        srst <= 0;
        @(posedge clk);
        #1;
        `CHK("reset state", ps_power_on, power_state)
        `CHK("reset ready", 1'b0, cmd_ready)
        start;
        foreach (rows[i])
        begin
            send(rows[i].cs, 1, rows[i].r, rows[i].f);
            hold(1, 1);
            collect;
            `CHK("kind", rows[i].k, got.kind)
            `CHK("refused", 1'b0, ill)
        end
        $display("Test table done");
        send(0, 1, rows[4].r, rows[4].f);
        send(0, 1, rows[6].r, rows[6].f);
        hold(1, 1);
        collect;
        `CHK("back to back", 2, n)
        @(posedge clk);
        eight_bank_cfg <= 1'b0;
        send(0, 1, 10'h004, 0);
        hold(1, 1);
        collect;
        `CHK("one bank refused", 1'b1, ill)
        @(posedge clk);
        eight_bank_cfg <= 1'b1;
        clk_resumed <= 1'b1; // Bus deselected, nothing in flight
        @(posedge clk);
        clk_resumed <= 1'b0;
        send(0, 1, rows[4].r, rows[4].f);
        hold(1, 1);
        collect;
        `CHK("not ready refused", 1'b1, ill)
        wait_rdy;
        send(0, 1, rows[0].r, rows[0].f); // Latency rewrite
        hold(1, 1);
        collect;
        `CHK("rewrite", cmd_mode_reg_write, got.kind)
        $display("Test refusals done");
        for (int a = 0; a < 2; a++)
        begin
            @(posedge clk);
            all_banks_idle <= a[0]; // Banks settled before entry
            send(1, 0, 0, 0);
            hold(0, 6); // No-op after entry, clock held
            wait_st(a[0] ? ps_pd_idle : ps_pd_active);
            send(1, 1, 0, 0);
            wait_st(ps_awake);
            wait_rdy;
            `CHK("exit wait", 1'b1, n >= CLK_RESUME_CYC - 1)
        end
        @(posedge clk);
        in_resetting <= 1'b1;
        for (int e = 0; e < 2; e++)
        begin
            @(posedge clk);
            init_final_expired <= !e[0];
            send(1, 0, 0, 0);
            hold(0, 6);
            wait_st(ps_pd_resetting);
            send(1, 1, 0, 0);
            wait_st(ps_awake);
            `CHK("to idle", !e[0], pd_exit_to_idle)
            wait_rdy;
        end
        @(posedge clk);
        in_resetting <= 1'b0;
        all_banks_idle <= 1'b0;
        send(0, 0, 10'h004, 0);
        hold(1, 1);
        collect;
        `CHK("busy entry", 1'b1, ill)
        `CHK("stay awake", ps_awake, power_state)
        @(posedge clk);
        all_banks_idle <= 1'b1;
        $display("Test power-down done");
        send(0, 0, 10'h004, 0);
        hold(0, 6);
        wait_st(ps_self_refresh_mode);
        send(1, 1, 0, 0);
        wait_st(ps_awake);
        `CHK("sr to idle", 1'b1, pd_exit_to_idle)
        wait_rdy;
        `CHK("sr wait", 1'b1, n >= SR_EXIT_CYC - 1)
        send(0, 0, 10'h003, 0);
        hold(0, 6);
        wait_st(ps_deep_sleep_mode);
        send(1, 1, 0, 0);
        wait_st(ps_power_on);
        start; // Full restart after deep sleep
        $display("Test sleep modes done");
        @(posedge clk);
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        `CHK("rerst state", ps_power_on, power_state)
        `CHK("rerst ready", 1'b0, cmd_ready)
        $display("Test mid reset done");
        end_sim;
    end
endmodule
`default_nettype wire
